/* hw/crs_alu.sv */
`timescale 1ns/1ps
module crs_alu (
  crs_alu_if.alu bus
);
  import crs_pkg::*;

  logic [8:0] sum;
  logic [4:0] low;
  logic cin;
  logic fix_lo;
  logic fix_hi;

  always_comb begin
    cin = (bus.op == OP_ADC) ? bus.c_in : 1'b0;
    sum = {1'b0, bus.a} + {1'b0, bus.m} + {8'h00, cin};
    low = {1'b0, bus.a[3:0]} + {1'b0, bus.m[3:0]} + {4'h0, cin};
    fix_lo = bus.h_in || (bus.a[3:0] > BCD_NIBBLE_MAX);
    fix_hi = bus.c_in || (bus.a > BCD_BYTE_MAX);
    bus.result = bus.a;
    bus.v = bus.v_in;
    bus.h = bus.h_in;
    bus.c = bus.c_in;
    bus.wr_acc = 1'b1;
    bus.hit = 1'b1;
    case (bus.op)
      OP_ADD, OP_ADC: begin
        bus.result = sum[7:0];
        bus.c = sum[8];
        bus.h = low[4];
        bus.v = (bus.a[7] == bus.m[7]) && (sum[7] != bus.a[7]);
      end
      OP_SUB: begin
        sum = {1'b0, bus.a} - {1'b0, bus.m};
        bus.result = sum[7:0];
        bus.c = sum[8];
        bus.v = (bus.a[7] != bus.m[7]) && (sum[7] != bus.a[7]);
      end
      OP_AND: begin
        bus.result = bus.a & bus.m;
        bus.v = 1'b0;
      end
      OP_ORA: begin
        bus.result = bus.a | bus.m;
        bus.v = 1'b0;
      end
      OP_EOR: begin
        bus.result = bus.a ^ bus.m;
        bus.v = 1'b0;
      end
      OP_LOAD_A: begin
        bus.result = bus.m;
        bus.v = 1'b0;
      end
      OP_SHIFT_L: begin
        bus.result = {bus.a[6:0], 1'b0};
        bus.c = bus.a[7];
        bus.v = bus.a[6] ^ bus.a[7];
      end
      OP_SHIFT_R: begin
        bus.result = {1'b0, bus.a[7:1]};
        bus.c = bus.a[0];
        bus.v = bus.a[0];
      end
      OP_BIT_TEST: begin
        // only carry changes; accumulator untouched
        bus.c = bus.m[bus.bit_sel];
        bus.wr_acc = 1'b0;
      end
      OP_DECIMAL_ADJUST: begin
        bus.result = bus.a + (fix_lo ? BCD_LOW_FIX : 8'h00)
                   + (fix_hi ? BCD_HIGH_FIX : 8'h00);
        bus.c = fix_hi;
      end
      default: begin
        bus.wr_acc = 1'b0;
        bus.hit = 1'b0;
      end
    endcase
    bus.n = bus.result[7];
    bus.z = (bus.result == 8'h00);
  end

endmodule // crs_alu

/* hw/crs_alu_if.sv */
`timescale 1ns/1ps
interface crs_alu_if;
  import crs_pkg::*;
  crs_op_type op;
  logic [7:0] a;
  logic [7:0] m;
  logic [2:0] bit_sel;
  logic v_in, h_in, c_in;
  logic [7:0] result;
  logic v, h, n, z, c;
  logic wr_acc;
  logic hit;
  modport core (output op, a, m, bit_sel, v_in, h_in, c_in,
                input result, v, h, n, z, c, wr_acc, hit);
  modport alu (input op, a, m, bit_sel, v_in, h_in, c_in,
               output result, v, h, n, z, c, wr_acc, hit);
endinterface

/* hw/crs_pkg.sv */
// Summary of operation
// - 8-bit accumulator feeds and takes ALU results
// - 16-bit index from separately accessible bytes
// - indexed operand address comes from index
// - reset presets stack pointer to 00FF
// - stack reload sets low byte FF only
// - push decrements, pull increments stack pointer
// - stack offset of 8 or 16 bits
// - program counter increments on every fetch
// - leaving reset loads vector FFFE high, FFFF low
// - flag register bits 6, 5 read one
// - overflow flag tracks signed overflow, branches
// - half-carry on carry from bit 3
// - decimal adjust uses half-carry and carry
// - interrupt mask set blocks maskable interrupts
// - accepted interrupt sets the interrupt mask; irq_take leaves I unchanged, the datapath issues OP_INT_MASK_SET
// - mask set after save, before vector
// - negative flag copies result bit 7
// - zero flag set when result is 00
// - carry from bit 7, borrow, shifts
package crs_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_ACC = 8'h00;
  localparam logic [7:0] OFS_INDEX = 8'h04;
  localparam logic [7:0] OFS_STACK = 8'h08;
  localparam logic [7:0] OFS_PC = 8'h0C;
  localparam logic [7:0] OFS_FLAGS = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // ****************************************
  // reset values and fixed addresses
  // ****************************************
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [15:0] HX_RESET = 16'h0000;
  localparam logic [15:0] SP_RESET = 16'h00FF;
  localparam logic [7:0] SP_LOW_RELOAD = 8'hFF;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] VEC_HI_ADDR = 16'hFFFE;
  localparam logic [15:0] VEC_LO_ADDR = 16'hFFFF;
  localparam logic [15:0] ONE16 = 16'h0001;

  // ****************************************
  // flag register layout
  // ****************************************
  localparam int FLG_V = 7;
  localparam int FLG_H = 4;
  localparam int FLG_I = 3;
  localparam int FLG_N = 2;
  localparam int FLG_Z = 1;
  localparam int FLG_C = 0;
  localparam logic [7:0] FLG_ONES = 8'h60;

  // ****************************************
  // decimal adjust constants
  // ****************************************
  localparam logic [7:0] BCD_LOW_FIX = 8'h06;
  localparam logic [7:0] BCD_HIGH_FIX = 8'h60;
  localparam logic [3:0] BCD_NIBBLE_MAX = 4'h9;
  localparam logic [7:0] BCD_BYTE_MAX = 8'h99;

  typedef enum logic [4:0] {
    OP_NOP, OP_ADD, OP_ADC, OP_SUB, OP_AND, OP_ORA, OP_EOR, OP_LOAD_A,
    OP_SHIFT_L, OP_SHIFT_R, OP_BIT_TEST, OP_DECIMAL_ADJUST, OP_LOAD_H,
    OP_LOAD_X, OP_PUSH, OP_PULL, OP_STACK_LOW_RELOAD, OP_FETCH, OP_JUMP,
    OP_INT_MASK_SET, OP_INT_MASK_CLEAR, OP_BRANCH_GREATER,
    OP_BRANCH_GREATER_EQUAL, OP_BRANCH_LESS_EQUAL, OP_BRANCH_LESS,
    OP_LOAD_FLAGS
  } crs_op_type;

  typedef enum logic [1:0] {
    EA_DIRECT, EA_INDEXED, EA_STACK8, EA_STACK16
  } crs_ea_type;

  typedef enum logic [2:0] {
    ST_VEC_HI = 3'b001,
    ST_VEC_LO = 3'b010,
    ST_RUN = 3'b100
  } crs_state_type;

  typedef struct packed {
    crs_state_type st;
    logic [7:0] acc;
    logic [15:0] hx;
    logic [15:0] sp;
    logic [15:0] pc;
    logic v, h, i, n, z, c;
    logic [31:0] rdata;
  } crs_regs_type;

endpackage

/* hw/crs_regset.sv */
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
module crs_regset (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [crs_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic op_valid,
  input wire crs_pkg::crs_op_type op_code,
  input wire logic [7:0] op_data,
  input wire logic [15:0] op_offset,
  input wire crs_pkg::crs_ea_type ea_mode,
  output logic [15:0] ea_addr,
  input wire logic irq_req,
  output logic irq_take,
  output logic mem_req,
  output logic [15:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [7:0] mem_rdata,
  output logic run,
  output logic [7:0] acc_out,
  output logic [15:0] hx_out,
  output logic [15:0] sp_out,
  output logic [15:0] pc_out,
  output logic [7:0] flags_out
);
  import crs_pkg::*;

  crs_regs_type q;
  crs_regs_type d;
  crs_alu_if alu_bus ();
  logic op_go;
  logic apb_wr;
  logic apb_hit;
  logic signed_lt;
  logic [7:0] flags;
  logic [31:0] rd_mux;

  crs_alu u_alu (
    .bus(alu_bus)
  );

  // ****************************************
  // flag packing and bus decode
  // ****************************************
  always_comb begin
    flags = FLG_ONES;
    flags[FLG_V] = q.v;
    flags[FLG_H] = q.h;
    flags[FLG_I] = q.i;
    flags[FLG_N] = q.n;
    flags[FLG_Z] = q.z;
    flags[FLG_C] = q.c;
  end

  always_comb begin
    apb_hit = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      OFS_ACC: rd_mux[7:0] = q.acc;
      OFS_INDEX: rd_mux[15:0] = q.hx;
      OFS_STACK: rd_mux[15:0] = q.sp;
      OFS_PC: rd_mux[15:0] = q.pc;
      OFS_FLAGS: rd_mux[7:0] = flags;
      OFS_STATUS: rd_mux[2:0] = q.st;
      default: apb_hit = 1'b0;
    endcase
  end

  assign apb_wr = psel && penable && pwrite && apb_hit;
  assign op_go = op_valid && (q.st == ST_RUN);
  assign signed_lt = q.n ^ q.v;

  assign alu_bus.op = op_code;
  assign alu_bus.a = q.acc;
  assign alu_bus.m = op_data;
  assign alu_bus.bit_sel = op_offset[2:0];
  assign alu_bus.v_in = q.v;
  assign alu_bus.h_in = q.h;
  assign alu_bus.c_in = q.c;

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb begin
    d = q;
    // read data sampled in the setup cycle so prdata is a flop output
    if (psel && !penable) begin
      d.rdata = rd_mux;
    end
    case (q.st)
      ST_VEC_HI: begin
        if (mem_ack) begin
          d.pc[15:8] = mem_rdata;
          d.st = ST_VEC_LO;
        end
      end
      ST_VEC_LO: begin
        if (mem_ack) begin
          d.pc[7:0] = mem_rdata;
          d.st = ST_RUN;
        end
      end
      ST_RUN: begin
      end
      default: d.st = ST_VEC_HI;
    endcase
    // bus writes first, so a datapath step in the same cycle wins
    if (apb_wr) begin
      case (paddr)
        OFS_ACC: d.acc = pwdata[7:0];
        OFS_INDEX: d.hx = pwdata[15:0];
        OFS_STACK: d.sp = pwdata[15:0];
        OFS_PC: d.pc = pwdata[15:0];
        OFS_FLAGS: begin
          // bits 6 and 5 have no storage, so writes cannot touch them
          d.v = pwdata[FLG_V];
          d.h = pwdata[FLG_H];
          d.i = pwdata[FLG_I];
          d.n = pwdata[FLG_N];
          d.z = pwdata[FLG_Z];
          d.c = pwdata[FLG_C];
        end
        default: d.st = q.st;
      endcase
    end
    if (op_go) begin
      if (alu_bus.hit) begin
        if (alu_bus.wr_acc) begin
          d.acc = alu_bus.result;
          d.n = alu_bus.n;
          d.z = alu_bus.z;
          d.v = alu_bus.v;
          d.h = alu_bus.h;
        end
        d.c = alu_bus.c;
      end
      case (op_code)
        OP_LOAD_H: d.hx[15:8] = op_data;
        OP_LOAD_X: d.hx[7:0] = op_data;
        OP_PUSH: d.sp = q.sp - ONE16;
        OP_PULL: d.sp = q.sp + ONE16;
        OP_STACK_LOW_RELOAD: d.sp[7:0] = SP_LOW_RELOAD;
        OP_FETCH: d.pc = q.pc + ONE16;
        OP_JUMP: d.pc = op_offset;
        // issued once the registers are stacked, ahead of the vector
        OP_INT_MASK_SET: d.i = 1'b1;
        OP_INT_MASK_CLEAR: d.i = 1'b0;
        OP_BRANCH_GREATER: begin
          if (!(q.z || signed_lt)) begin
            d.pc = op_offset;
          end
        end
        OP_BRANCH_GREATER_EQUAL: begin
          if (!signed_lt) begin
            d.pc = op_offset;
          end
        end
        OP_BRANCH_LESS_EQUAL: begin
          if (q.z || signed_lt) begin
            d.pc = op_offset;
          end
        end
        OP_BRANCH_LESS: begin
          if (signed_lt) begin
            d.pc = op_offset;
          end
        end
        OP_LOAD_FLAGS: begin
          d.v = op_data[FLG_V];
          d.h = op_data[FLG_H];
          d.i = op_data[FLG_I];
          d.n = op_data[FLG_N];
          d.z = op_data[FLG_Z];
          d.c = op_data[FLG_C];
        end
        default: d.st = q.st;
      endcase
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q.st <= ST_VEC_HI;
      q.acc <= ACC_RESET;
      q.hx <= HX_RESET;
      q.sp <= SP_RESET;
      q.pc <= PC_RESET;
      q.v <= 1'b0;
      q.h <= 1'b0;
      q.i <= 1'b1;
      q.n <= 1'b0;
      q.z <= 1'b0;
      q.c <= 1'b0;
      q.rdata <= 32'h0000_0000;
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  always_comb begin
    case (ea_mode)
      EA_INDEXED: ea_addr = q.hx + op_offset;
      EA_STACK8: ea_addr = q.sp + {8'h00, op_offset[7:0]};
      EA_STACK16: ea_addr = q.sp + op_offset;
      default: ea_addr = op_offset;
    endcase
  end

  // datapath must follow irq_take with stacking, then OP_INT_MASK_SET
  assign irq_take = irq_req && !q.i && (q.st == ST_RUN);
  assign mem_req = (q.st == ST_VEC_HI) || (q.st == ST_VEC_LO);
  assign mem_addr = (q.st == ST_VEC_LO) ? VEC_LO_ADDR : VEC_HI_ADDR;
  assign run = (q.st == ST_RUN);
  assign prdata = q.rdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !apb_hit;
  assign acc_out = q.acc;
  assign hx_out = q.hx;
  assign sp_out = q.sp;
  assign pc_out = q.pc;
  assign flags_out = flags;

  // ****************************************
  // checks
  // ****************************************
  property p_stack_reload;
    @(posedge pclk) disable iff (!presetn)
    op_go && op_code == OP_STACK_LOW_RELOAD && !apb_wr
      |=> sp_out == {$past(sp_out[15:8]), SP_LOW_RELOAD};
  endproperty
  a_stack_reload: assert property (p_stack_reload) else $error("stack reload wrong");

  property p_push_pull;
    @(posedge pclk) disable iff (!presetn)
    op_go && !apb_wr && (op_code == OP_PUSH || op_code == OP_PULL)
      |=> sp_out == ($past(op_code) == OP_PUSH ? $past(sp_out) - ONE16
                                                : $past(sp_out) + ONE16);
  endproperty
  a_push_pull: assert property (p_push_pull) else $error("stack step wrong");

  property p_fetch;
    @(posedge pclk) disable iff (!presetn)
    op_go && op_code == OP_FETCH && !apb_wr |=> pc_out == $past(pc_out) + ONE16;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch did not advance pc");

  property p_vector;
    @(posedge pclk) disable iff (!presetn)
    q.st == ST_VEC_HI && mem_ack && !apb_wr
      |=> run == 1'b0 && mem_addr == VEC_LO_ADDR && pc_out[15:8] == $past(mem_rdata);
  endproperty
  a_vector: assert property (p_vector) else $error("vector high byte wrong");

  property p_fixed_ones;
    @(posedge pclk) disable iff (!presetn)
    psel && !penable && paddr == OFS_FLAGS |=> prdata[6:5] == 2'b11;
  endproperty
  a_fixed_ones: assert property (p_fixed_ones) else $error("flag bits 6,5 not one");

  property p_irq_block;
    @(posedge pclk) disable iff (!presetn)
    flags_out[FLG_I] |-> !irq_take;
  endproperty
  a_irq_block: assert property (p_irq_block) else $error("interrupt taken while masked");

  property p_mask_set;
    @(posedge pclk) disable iff (!presetn)
    op_go && op_code == OP_INT_MASK_SET |=> flags_out[FLG_I];
  endproperty
  a_mask_set: assert property (p_mask_set) else $error("mask not set on entry");

  property p_add_nz;
    @(posedge pclk) disable iff (!presetn)
    op_go && op_code == OP_ADD
      |=> flags_out[FLG_Z] == (acc_out == 8'h00) && flags_out[FLG_N] == acc_out[7];
  endproperty
  a_add_nz: assert property (p_add_nz) else $error("n or z wrong after add");

  property p_add_carry;
    @(posedge pclk) disable iff (!presetn)
    op_go && op_code == OP_ADD
      |=> flags_out[FLG_C] == (({1'b0, $past(acc_out)} + {1'b0, $past(op_data)}) > 9'h0FF);
  endproperty
  a_add_carry: assert property (p_add_carry) else $error("carry wrong after add");

  property p_stack_ea;
    @(posedge pclk) disable iff (!presetn)
    ea_mode == EA_STACK8 |-> ea_addr == sp_out + {8'h00, op_offset[7:0]};
  endproperty
  a_stack_ea: assert property (p_stack_ea) else $error("stack offset address wrong");

endmodule // crs_regset

/* verif/cpu_register_set_tb.sv */
`timescale 1ns/1ps
module cpu_register_set_tb;
  import crs_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, op_valid, irq_req, irq_take;
  logic mem_req, mem_ack, run, slow;
  logic [7:0] paddr, op_data, acc_out, flags_out, mem_rdata;
  logic [31:0] pwdata, prdata;
  logic [15:0] op_offset, ea_addr, mem_addr, hx_out, sp_out, pc_out, vec;
  crs_op_type op_code;
  crs_ea_type ea_mode;
  logic [33:0] q[$];
  int errors, checked;

  crs_regset DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .op_valid(op_valid), .op_code(op_code), .op_data(op_data),
    .op_offset(op_offset), .ea_mode(ea_mode), .ea_addr(ea_addr), .irq_req(irq_req),
    .irq_take(irq_take), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .run(run), .acc_out(acc_out), .hx_out(hx_out),
    .sp_out(sp_out), .pc_out(pc_out), .flags_out(flags_out));
  crs_mem_model mem (.pclk(pclk), .presetn(presetn), .slow(slow), .vec(vec),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // ****************************************
  // checking and verdict
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    if (errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && q.size() > 0) begin
      chk(pslverr, q[0][32]);
      if (!q[0][33]) chk(prdata, q[0][31:0]);
      void'(q.pop_front());
    end
  end

  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    report_and_stop;
  end

  // ****************************************
  // bus and datapath drivers
  // ****************************************
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    q.push_back({w, e});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b0, e});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask

  task automatic op(input crs_op_type c, input logic [7:0] d, input logic [15:0] o);
    op_valid <= 1'b1;
    op_code <= c;
    op_data <= d;
    op_offset <= o;
    @(posedge pclk);
    op_valid <= 1'b0;
    @(posedge pclk);
  endtask

  // op held through reset and the high vector byte fetch must be ignored
  task automatic boot(input logic s);
    int n;
    slow <= s;
    vec <= 16'($urandom);
    presetn <= 1'b0;
    op_valid <= 1'b1;
    op_code <= OP_LOAD_A;
    op_data <= 8'h5A;
    repeat (10) @(posedge pclk);
    chk(sp_out, SP_RESET);
    chk(flags_out, 8'h68);
    chk(mem_addr, VEC_HI_ADDR);
    chk(mem_req, 1'b1);
    presetn <= 1'b1;
    for (n = 0; n < 50 && mem_addr !== VEC_LO_ADDR; n++) @(posedge pclk);
    op_valid <= 1'b0;
    for (n = 0; n < 50 && run !== 1'b1; n++) @(posedge pclk);
    chk(run, 1'b1);
    chk(mem_req, 1'b0);
    rd(OFS_ACC, 32'h0);
    rd(OFS_PC, {16'h0, vec});
    rd(OFS_STACK, 32'h00FF);
    rd(OFS_STATUS, 32'h4);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [7:0] a, m, r, f, fe, mk;
    logic [8:0] s;
    logic [15:0] t, ex;
    crs_op_type k;
    {psel, penable, pwrite, op_valid, irq_req, slow} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    op_code = OP_NOP;
    op_data = 8'h00;
    op_offset = 16'h0000;
    ea_mode = EA_DIRECT;
    presetn = 1'b0;
    vec = 16'h0000;
    errors = 0;
    checked = 0;
    void'($urandom(32'he8983eaa));
    @(posedge pclk);
    boot(1'b1);
    apb(1'b1, 8'h18, 32'hFFFFFFFF, {1'b1, 32'h0});
    apb(1'b0, 8'h18, 32'h0, {1'b1, 32'h0});
    wr(OFS_FLAGS, 32'h0);
    rd(OFS_FLAGS, 32'h60);
    wr(OFS_FLAGS, 32'hFF);
    rd(OFS_FLAGS, 32'hFF);
    for (int i = 0; i < 18; i++) begin
      a = 8'($urandom);
      m = 8'($urandom);
      f = (8'($urandom) & 8'h97) | 8'h08;
      k = crs_op_type'(1 + i % 6);
      if (i == 0) begin
        a = 8'h80;
        m = 8'h80;
        k = OP_ADD;
      end
      wr(OFS_ACC, {24'h0, a});
      wr(OFS_FLAGS, {24'h0, f});
      op(k, m, 16'h0);
      case (k)
        OP_ADD, OP_ADC: s = a + m + ((k == OP_ADC) ? f[0] : 1'b0);
        OP_SUB: s = {1'b0, a} - {1'b0, m};
        OP_AND: s = {1'b0, a & m};
        OP_ORA: s = {1'b0, a | m};
        default: s = {1'b0, a ^ m};
      endcase
      r = s[7:0];
      fe = {3'b011, f[4], 1'b1, r[7], r == 8'h00, f[0]};
      if (k == OP_ADD || k == OP_ADC)
        fe = {a[7] == m[7] && r[7] != a[7], 2'b11, a[4] ^ m[4] ^ r[4], 1'b1, fe[2:1], s[8]};
      if (k == OP_SUB)
        fe = {a[7] != m[7] && r[7] != a[7], 2'b11, 2'b01, fe[2:1], s[8]};
      mk = (k == OP_SUB) ? 8'hEF : 8'hFF;
      rd(OFS_ACC, {24'h0, r});
      chk(flags_out & mk, fe & mk);
    end
    for (int b = 0; b < 8; b++) begin
      a = 8'($urandom);
      op(OP_BIT_TEST, a, 16'(b));
      chk(flags_out[FLG_C], a[b]);
    end
    a = 8'($urandom);
    m = 8'($urandom);
    wr(OFS_FLAGS, 32'h08);
    op(OP_LOAD_A, a, 16'h0);
    chk(acc_out, a);
    op(OP_SHIFT_L, 8'h00, 16'h0);
    chk(flags_out, {a[6] ^ a[7], 2'b11, 2'b01, a[6], a[6:0] == 7'h00, a[7]});
    op(OP_SHIFT_R, 8'h00, 16'h0);
    chk(acc_out, {1'b0, a[6:0]});
    chk(flags_out, {4'b0110, 1'b1, 1'b0, a[6:0] == 7'h00, 1'b0});
    op(OP_LOAD_FLAGS, m, 16'h0);
    chk(flags_out, m | 8'h60);
    wr(OFS_ACC, 32'h19);
    wr(OFS_FLAGS, 32'h08);
    op(OP_ADD, 8'h28, 16'h0);
    op(OP_DECIMAL_ADJUST, 8'h00, 16'h0);
    chk(acc_out, 8'h47);
    wr(OFS_ACC, 32'h41);
    wr(OFS_FLAGS, 32'h09);
    op(OP_DECIMAL_ADJUST, 8'h00, 16'h0);
    chk(acc_out, 8'hA1);
    a = 8'($urandom);
    m = 8'($urandom);
    op(OP_LOAD_H, a, 16'h0);
    op(OP_LOAD_X, m, 16'h0);
    rd(OFS_INDEX, {16'h0, a, m});
    wr(OFS_STACK, 32'h0234);
    op(OP_PUSH, 8'h00, 16'h0);
    op(OP_PUSH, 8'h00, 16'h0);
    chk(sp_out, 16'h0232);
    op(OP_PULL, 8'h00, 16'h0);
    chk(sp_out, 16'h0233);
    op(OP_STACK_LOW_RELOAD, 8'h00, 16'h0);
    chk(sp_out, 16'h02FF);
    t = 16'($urandom);
    for (int e = 0; e < 4; e++) begin
      ea_mode <= crs_ea_type'(e);
      op_offset <= t;
      @(posedge pclk);
      case (e)
        0: ex = t;
        1: ex = {a, m} + t;
        2: ex = 16'h02FF + {8'h00, t[7:0]};
        default: ex = 16'h02FF + t;
      endcase
      chk(ea_addr, ex);
    end
    op(OP_JUMP, 8'h00, 16'h4000);
    op(OP_FETCH, 8'h00, 16'h0);
    chk(pc_out, 16'h4001);
    for (int j = 0; j < 2; j++) begin
      wr(OFS_FLAGS, j ? 32'h0C : 32'h08);
      for (int b = 0; b < 4; b++) begin
        op(OP_JUMP, 8'h00, 16'h4000);
        op(crs_op_type'(OP_BRANCH_GREATER + b), 8'h00, 16'h1230 + 16'(b));
        chk(pc_out, ((j != 0) == (b > 1)) ? 16'h1230 + 16'(b) : 16'h4000);
      end
    end
    irq_req <= 1'b1;
    @(posedge pclk);
    @(posedge pclk);
    chk(irq_take, 1'b0);
    op(OP_INT_MASK_CLEAR, 8'h00, 16'h0);
    chk(irq_take, 1'b1);
    op(OP_PUSH, 8'h00, 16'h0);
    op(OP_INT_MASK_SET, 8'h00, 16'h0);
    chk(flags_out[FLG_I], 1'b1);
    chk(irq_take, 1'b0);
    irq_req <= 1'b0;
    boot(1'b0);
    report_and_stop;
  end
endmodule // cpu_register_set_tb

/* verif/crs_mem_model.sv */
`timescale 1ns/1ps
module crs_mem_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic [15:0] vec,
  input wire logic mem_req,
  input wire logic [15:0] mem_addr,
  output logic mem_ack,
  output logic [7:0] mem_rdata
);
  logic [1:0] wait_q;
  // ****************************************
  // vector memory, prompt or late: three cycles for the high byte, two for the low byte
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      wait_q <= 2'h0;
      mem_rdata <= 8'hA5;
    end else if (mem_req && !mem_ack && wait_q >= (slow ? 2'h3 : 2'h0)) begin
      mem_ack <= 1'b1;
      wait_q <= 2'h0;
      mem_rdata <= (mem_addr == 16'hFFFE) ? vec[15:8] : vec[7:0];
    end else begin
      mem_ack <= 1'b0;
      wait_q <= mem_req ? wait_q + 2'h1 : 2'h0;
      // released bus never keeps the last byte
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule // crs_mem_model
